// ===== qp_pkg.sv
// Shared constants, types and command layout of the quad pot serial control core.
// Assumes a single 25 MHz system clock and a serial link clocked by the host.
package qp_pkg;

   // Geometry of the pot bank
   localparam int unsigned POTS = 4;
   localparam int unsigned SETS = 4;
   localparam int unsigned TAPS = 64;

   // Identification byte: device type code is arbitrary, spare bits are zero
   localparam logic [3:0] ID_TYPE = 4'h3;
   localparam logic [1:0] ID_SPARE = 2'h0;

   // Instruction opcodes, upper nibble of the instruction byte
   localparam logic [3:0] OP_RD_WIPER = 4'h9;
   localparam logic [3:0] OP_WR_WIPER = 4'ha;
   localparam logic [3:0] OP_RD_SET = 4'hb;
   localparam logic [3:0] OP_WR_SET = 4'hc;
   localparam logic [3:0] OP_XFR_SET_TO_WIPER = 4'hd;
   localparam logic [3:0] OP_XFR_WIPER_TO_SET = 4'he;
   localparam logic [3:0] OP_GXFR_SET_TO_WIPER = 4'h1;
   localparam logic [3:0] OP_GXFR_WIPER_TO_SET = 4'h8;
   localparam logic [3:0] OP_RD_STATUS = 4'h5;
   localparam logic [3:0] OP_INCDEC = 4'h2;

   // Field positions and limits
   localparam logic [2:0] LAST_BIT = 3'h7;
   localparam int unsigned STATUS_WIP_POS = 0;
   localparam logic [5:0] WIPER_MAX = 6'h3f;
   localparam logic [6:0] STEP_MAX = 7'h3f;
   localparam logic [6:0] STEP_MIN = 7'h41;

   // Values after reset
   localparam logic [5:0] SETTING_RESET = 6'h20;
   localparam logic [63:0] TAP_RESET = 64'h1 << SETTING_RESET;

   // Nonvolatile save time, longest figure, rounded down to cycles
   localparam int unsigned NV_WRITE_TIME_US = 10000;
   localparam int unsigned CLK_FREQ_KHZ = 25000;
   localparam int unsigned NV_WRITE_CYCLES = NV_WRITE_TIME_US * CLK_FREQ_KHZ / 1000;
   localparam int unsigned NV_CNT_W = 18;

   // Link sequencer states
   typedef enum logic [4:0] {
      LS_ID = 5'b00001,
      LS_INSTR = 5'b00010,
      LS_DATA = 5'b00100,
      LS_STEP = 5'b01000,
      LS_IGNORE = 5'b10000
   } qp_link_state_t;

   // Instruction byte layout
   typedef struct packed {
      logic [3:0] op;
      logic [1:0] sel;
      logic [1:0] pot;
   } qp_instr_t;

   // Command record handed from the link to the system clock
   typedef struct packed {
      qp_instr_t instr;
      logic [5:0] data;
      logic [6:0] step;
   } qp_cmd_t;

endpackage

// ===== qp_serial_ctrl.sv
// Serial control core of a quad digital potentiometer: link sequencer, wiper
// and setting registers, nonvolatile save timing and tap decode.
// Assumes the host is an SPI master; sck only toggles while csN is low.
`timescale 1ns/100ps
`default_nettype none

module qp_serial_ctrl #(
   parameter int unsigned NV_CYCLES = qp_pkg::NV_WRITE_CYCLES
) (
   // System
   input wire logic clk,
   input wire logic reset,
   // Serial link
   input wire logic sck,
   input wire logic csN,
   input wire logic si,
   input wire logic holdN,
   output logic soOut,
   output logic soOe,
   // Straps and protection
   input wire logic [1:0] deviceSelect,
   input wire logic writeProtectN,
   // Pot bank
   output logic [qp_pkg::POTS-1:0][qp_pkg::TAPS-1:0] tapEnable,
   output logic writeInProgress
);
   import qp_pkg::*;

   localparam logic [NV_CNT_W-1:0] NV_LAST = NV_CNT_W'(NV_CYCLES - 1);

   // Storage, system clock domain
   logic [5:0] wiper [POTS];
   logic [5:0] setting [POTS][SETS];
   logic [5:0] next_wiper [POTS];
   logic [5:0] next_setting [POTS][SETS];
   logic [POTS-1:0][TAPS-1:0] next_tapEnable;
   logic write_in_progress_flag;
   logic next_wip;
   logic [NV_CNT_W-1:0] nvCnt;
   logic [NV_CNT_W-1:0] next_nvCnt;
   logic recall;
   logic csSync1, csSync2, csSync3;
   logic wpSync1, wpSync2;
   logic ackClr;
   logic frameEnd;

   // Link domain state
   qp_link_state_t state, next_state;
   logic [2:0] bitCnt, next_bitCnt;
   logic [7:0] shiftIn, next_shiftIn;
   logic [7:0] readWord, next_readWord;
   logic reading, next_reading;
   qp_cmd_t cmd, next_cmd;
   logic cmdValid, next_cmdValid;
   logic [1:0] selSync1, selSync2;
   logic wipLink1, wipLink2;
   logic [7:0] byteIn;
   qp_instr_t instrIn;

   // Wiper plus signed step, held inside the end stops
   function automatic logic [5:0] clampStep(input logic [5:0] w, input logic [6:0] s);
      logic [7:0] sum;
      sum = {2'h0, w} + {s[6], s};
      if (sum[7]) begin
         return 6'h00;
      end else if (sum > {2'h0, WIPER_MAX}) begin
         return WIPER_MAX;
      end
      return sum[5:0];
   endfunction

   // ---------------- Link domain, rising sck ----------------

   // Straps and busy flag into the link clock
   always_ff @(posedge sck or posedge csN) begin
      if (csN) begin
         selSync1 <= 2'h0;
         selSync2 <= 2'h0;
         wipLink1 <= 1'b0;
         wipLink2 <= 1'b0;
      end else begin
         selSync1 <= deviceSelect;
         selSync2 <= selSync1;
         wipLink1 <= write_in_progress_flag;
         wipLink2 <= wipLink1;
      end
   end

   assign byteIn = {shiftIn[6:0], si};
   assign instrIn = byteIn;

   // Sequencer next values
   always_comb begin
      next_state = state;
      next_bitCnt = bitCnt;
      next_shiftIn = shiftIn;
      next_readWord = readWord;
      next_reading = reading;
      next_cmd = cmd;
      next_cmdValid = cmdValid;
      if (holdN) begin
         next_bitCnt = bitCnt + 3'h1;
         next_shiftIn = byteIn;
         case (state)
            LS_ID: begin
               if (bitCnt == 3'h0) begin
                  next_cmdValid = 1'b0;
               end
               if (bitCnt == LAST_BIT) begin
                  if (byteIn[7:4] == ID_TYPE && byteIn[1:0] == selSync2) begin
                     next_state = LS_INSTR;
                  end else begin
                     next_state = LS_IGNORE;
                  end
               end
            end
            LS_INSTR: begin
               if (bitCnt == LAST_BIT) begin
                  next_cmd.instr = instrIn;
                  next_cmd.step = 7'h00;
                  next_state = LS_IGNORE;
                  next_reading = 1'b0;
                  case (instrIn.op)
                     OP_XFR_SET_TO_WIPER, OP_XFR_WIPER_TO_SET,
                     OP_GXFR_SET_TO_WIPER, OP_GXFR_WIPER_TO_SET: begin
                        next_cmdValid = 1'b1;
                     end
                     OP_WR_WIPER, OP_WR_SET: begin
                        next_state = LS_DATA;
                     end
                     OP_RD_WIPER: begin
                        next_state = LS_DATA;
                        next_reading = 1'b1;
                        next_readWord = {2'h0, wiper[instrIn.pot]};
                     end
                     OP_RD_SET: begin
                        next_state = LS_DATA;
                        next_reading = 1'b1;
                        next_readWord = {2'h0, setting[instrIn.pot][instrIn.sel]};
                     end
                     OP_RD_STATUS: begin
                        next_state = LS_DATA;
                        next_reading = 1'b1;
                        next_readWord = 8'h00;
                        next_readWord[STATUS_WIP_POS] = wipLink2;
                     end
                     OP_INCDEC: begin
                        next_state = LS_STEP;
                        next_cmdValid = 1'b1;
                     end
                     default: begin
                        next_state = LS_IGNORE;
                     end
                  endcase
               end
            end
            LS_DATA: begin
               if (bitCnt == LAST_BIT) begin
                  next_state = LS_IGNORE;
                  next_reading = 1'b0;
                  if (!reading) begin
                     next_cmd.data = byteIn[5:0];
                     next_cmdValid = 1'b1;
                  end
               end
            end
            LS_STEP: begin
               // Net step count, limited to the span of the array
               if (si && cmd.step != STEP_MAX) begin
                  next_cmd.step = cmd.step + 7'h01;
               end else if (!si && cmd.step != STEP_MIN) begin
                  next_cmd.step = cmd.step - 7'h01;
               end
            end
            LS_IGNORE: begin
               next_state = LS_IGNORE;
            end
            default: begin
               next_state = LS_IGNORE;
            end
         endcase
      end
   end

   // Sequencer registers, cleared while deselected
   always_ff @(posedge sck or posedge csN) begin
      if (csN) begin
         state <= LS_ID;
         bitCnt <= 3'h0;
         shiftIn <= 8'h00;
         readWord <= 8'h00;
         reading <= 1'b0;
      end else begin
         state <= next_state;
         bitCnt <= next_bitCnt;
         shiftIn <= next_shiftIn;
         readWord <= next_readWord;
         reading <= next_reading;
      end
   end

   // Command valid, cleared by the system side after it is consumed
   always_ff @(posedge sck or posedge ackClr) begin
      if (ackClr) begin
         cmdValid <= 1'b0;
      end else begin
         cmdValid <= next_cmdValid;
      end
   end

   // Command record, only read while cmdValid is set
   always_ff @(posedge sck) begin
      cmd <= next_cmd;
   end

   // ---------------- Link domain, falling sck ----------------

   // Read data out, tri-stated otherwise
   always_ff @(negedge sck or posedge csN) begin
      if (csN) begin
         soOe <= 1'b0;
         soOut <= 1'b0;
      end else begin
         soOe <= reading & holdN;
         soOut <= reading ? readWord[LAST_BIT - bitCnt] : 1'b0;
      end
   end

   // ---------------- System clock domain ----------------

   // Pin synchronisers
   always_ff @(posedge clk) begin
      if (reset) begin
         csSync1 <= 1'b1;
         csSync2 <= 1'b1;
         csSync3 <= 1'b1;
         wpSync1 <= 1'b0;
         wpSync2 <= 1'b0;
         ackClr <= 1'b1;
      end else begin
         csSync1 <= csN;
         csSync2 <= csSync1;
         csSync3 <= csSync2;
         wpSync1 <= writeProtectN;
         wpSync2 <= wpSync1;
         ackClr <= frameEnd;
      end
   end

   // Frame end: sck is idle, so the command record is stable here
   assign frameEnd = csSync2 & ~csSync3;

   // Storage and save timer next values
   always_comb begin
      next_wiper = wiper;
      next_setting = setting;
      next_wip = write_in_progress_flag;
      next_nvCnt = nvCnt;
      if (write_in_progress_flag) begin
         if (nvCnt == '0) begin
            next_wip = 1'b0;
         end else begin
            next_nvCnt = nvCnt - 1'b1;
         end
      end
      if (recall) begin
         for (int p = 0; p < POTS; p++) begin
            next_wiper[p] = setting[p][0];
         end
      end else if (frameEnd && cmdValid) begin
         case (cmd.instr.op)
            OP_WR_WIPER: begin
               next_wiper[cmd.instr.pot] = cmd.data;
            end
            OP_XFR_SET_TO_WIPER: begin
               next_wiper[cmd.instr.pot] = setting[cmd.instr.pot][cmd.instr.sel];
            end
            OP_GXFR_SET_TO_WIPER: begin
               for (int p = 0; p < POTS; p++) begin
                  next_wiper[p] = setting[p][cmd.instr.sel];
               end
            end
            OP_INCDEC: begin
               next_wiper[cmd.instr.pot] = clampStep(wiper[cmd.instr.pot], cmd.step);
            end
            OP_WR_SET, OP_XFR_WIPER_TO_SET, OP_GXFR_WIPER_TO_SET: begin
               if (wpSync2 && !write_in_progress_flag) begin
                  next_wip = 1'b1;
                  next_nvCnt = NV_LAST;
                  if (cmd.instr.op == OP_WR_SET) begin
                     next_setting[cmd.instr.pot][cmd.instr.sel] = cmd.data;
                  end else if (cmd.instr.op == OP_XFR_WIPER_TO_SET) begin
                     next_setting[cmd.instr.pot][cmd.instr.sel] = wiper[cmd.instr.pot];
                  end else begin
                     for (int p = 0; p < POTS; p++) begin
                        next_setting[p][cmd.instr.sel] = wiper[p];
                     end
                  end
               end
            end
            default: begin
               next_wip = next_wip;
            end
         endcase
      end
   end

   // Storage and save timer registers
   always_ff @(posedge clk) begin
      if (reset) begin
         for (int p = 0; p < POTS; p++) begin
            wiper[p] <= SETTING_RESET;
            for (int s = 0; s < SETS; s++) begin
               setting[p][s] <= SETTING_RESET;
            end
         end
         write_in_progress_flag <= 1'b0;
         writeInProgress <= 1'b0;
         nvCnt <= '0;
         recall <= 1'b1;
      end else begin
         wiper <= next_wiper;
         setting <= next_setting;
         write_in_progress_flag <= next_wip;
         writeInProgress <= next_wip;
         nvCnt <= next_nvCnt;
         recall <= 1'b0;
      end
   end

   // One-hot tap decode per pot
   for (genvar g = 0; g < POTS; g++) begin : gTap
      assign next_tapEnable[g] = 64'h1 << next_wiper[g];

      always_ff @(posedge clk) begin
         if (reset) begin
            tapEnable[g] <= TAP_RESET;
         end else begin
            tapEnable[g] <= next_tapEnable[g];
         end
      end
   end

endmodule // qp_serial_ctrl

`default_nettype wire

// ===== qp_serial_ctrl_chk.sv
// Checker of the quad pot serial core, seeing only its top ports.
// Assumes one command per csN low period and several clk between frames.
`timescale 1ns/100ps
`default_nettype none
module qp_serial_ctrl_chk import qp_pkg::*; #(
   parameter int unsigned NV_CYCLES = 20
) (
   // System
   input wire logic clk,
   input wire logic reset,
   // Serial link
   input wire logic sck,
   input wire logic csN,
   input wire logic si,
   input wire logic holdN,
   input wire logic soOut,
   input wire logic soOe,
   // Straps and pot bank
   input wire logic [1:0] deviceSelect,
   input wire logic writeProtectN,
   input wire logic [qp_pkg::POTS-1:0][qp_pkg::TAPS-1:0] tapEnable,
   input wire logic writeInProgress
);
   logic [4:0] bitCnt;
   logic [7:0] shift;
   logic idOk;
   logic rdOk;
   int unsigned wipCnt;
   // Frame bit count, identification and read decode, cleared while deselected
   always_ff @(posedge sck or posedge csN) begin
      if (csN) begin
         bitCnt <= 5'h0;
         shift <= 8'h0;
         idOk <= 1'b0;
         rdOk <= 1'b0;
      end else if (holdN && bitCnt != 5'h1f) begin
         bitCnt <= bitCnt + 5'h1;
         shift <= {shift[6:0], si};
         if (bitCnt == 5'h7)
            idOk <= ({shift[6:3], shift[0], si} == {ID_TYPE, deviceSelect});
         if (bitCnt == 5'hf)
            rdOk <= idOk && (shift[6:3] inside {OP_RD_WIPER, OP_RD_SET, OP_RD_STATUS});
      end
   end
   // Length of the running save
   always_ff @(posedge clk) begin
      if (reset || !writeInProgress)
         wipCnt <= 0;
      else
         wipCnt <= wipCnt + 1;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   deselect_hiz_a: assert property (csN |-> !soOe)
      else $error("output driven while deselected");
   write_quiet_a: assert property (!rdOk |-> !soOe)
      else $error("output driven outside a read");
   read_drive_a: assert property (rdOk && bitCnt > 5'h10 && bitCnt < 5'h19 && holdN |-> soOe)
      else $error("read byte not driven");
   read_release_a: assert property (bitCnt > 5'h18 |-> !soOe)
      else $error("output held after read byte");
   tap_onehot_a: assert property ($onehot(tapEnable[0]) && $onehot(tapEnable[1])
      && $onehot(tapEnable[2]) && $onehot(tapEnable[3])) else $error("tap enable not one-hot");
   recall_zero_a: assert property ($fell(reset) |-> (tapEnable == {4{TAP_RESET}}) [*2])
      else $error("wrong wiper after reset");
   apply_at_end_a: assert property (!$stable(tapEnable) |-> csN && $past(csN, 2))
      else $error("wiper moved inside a frame");
   save_start_a: assert property ($rose(writeInProgress) |-> csN && $past(csN, 2))
      else $error("save started inside a frame");
   save_bound_a: assert property (writeInProgress |-> wipCnt < NV_CYCLES)
      else $error("save too long");
   protect_block_a: assert property (!writeProtectN && !$past(writeProtectN, 8)
      |-> !$rose(writeInProgress)) else $error("save while protected");
   cover property ($rose(writeInProgress));
   cover property ($rose(soOe));
   cover property (!$stable(tapEnable));
   cover property (soOe && soOut);
endmodule // qp_serial_ctrl_chk
bind qp_serial_ctrl qp_serial_ctrl_chk #(.NV_CYCLES(NV_CYCLES)) chk (.clk, .reset, .sck, .csN,
   .si, .holdN, .soOut, .soOe, .deviceSelect, .writeProtectN, .tapEnable, .writeInProgress);
`default_nettype wire

// ===== qp_host_model.sv
// Host SPI master model for the quad pot serial link, mode 0, MSB first.
// Assumes sck stands low outside frames; bit time 30 ns.
`timescale 1ns/100ps
`default_nettype none
module qp_host_model (
   // Link
   output logic sck,
   output logic csN,
   output logic si,
   output logic holdN,
   // Read data
   input wire logic soOut,
   input wire logic soOe
);
   logic lastSo = 1'b0;
   // Idle: deselected, pause released
   initial begin
      sck = 1'b0;
      csN = 1'b0;
      si = 1'b0;
      holdN = 1'b1;
      // Raise csN after time zero so the link flops see a clearing edge
      #1 csN = 1'b1;
   end
   // Frame opens with a csN fall while sck is low
   task automatic start();
      #7 csN = 1'b0;
      #15;
   endtask
   task automatic stop();
      #15 csN = 1'b1;
      #15;
   endtask
   // One bit; a released line reads as the inverse of the last bit
   task automatic bit1(input logic v, output logic r);
      si = v;
      #15 sck = 1'b1;
      r = soOe ? soOut : ~lastSo;
      lastSo = r;
      #15 sck = 1'b0;
   endtask
   task automatic xfer(input logic [7:0] b, output logic [7:0] r);
      for (int i = 7; i >= 0; i--) bit1(b[i], r[i]);
   endtask
   // Pause while sck is low; pulses meanwhile must be ignored
   task automatic pause();
      holdN = 1'b0;
      repeat (3) begin
         #15 sck = 1'b1;
         #15 sck = 1'b0;
      end
      holdN = 1'b1;
   endtask
endmodule // qp_host_model
`default_nettype wire

// ===== tb.sv
// Testbench of the quad pot serial core with host model and bound checker.
// Assumes 25 MHz clk and a save shortened to 60 cycles.
`timescale 1ns/100ps
`default_nettype none
module tb import qp_pkg::*;;
   localparam int unsigned NV = 60;
   localparam logic [7:0] ID1 = {ID_TYPE, ID_SPARE, 2'h1};
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic [1:0] deviceSelect = 2'h1;
   logic writeProtectN = 1'b1;
   logic sck, csN, si, holdN, soOut, soOe, writeInProgress;
   logic [POTS-1:0][TAPS-1:0] tapEnable;
   logic [7:0] rd;
   logic [5:0] vals [4] = '{6'h00, 6'h3f, 6'h2a, 6'h11};
   logic [5:0] g3 [4] = '{6'h00, 6'h3f, 6'h15, 6'h11};
   int bad_count = 0;
   int checks = 0;
   always #20 clk = ~clk;
   qp_serial_ctrl #(.NV_CYCLES(NV)) DUT (.clk, .reset, .sck, .csN, .si, .holdN, .soOut,
      .soOe, .deviceSelect, .writeProtectN, .tapEnable, .writeInProgress);
   qp_host_model host (.sck, .csN, .si, .holdN, .soOut, .soOe);
   task automatic check(input string what, input logic [63:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Command frame; n 2 or 3 bytes, 4 adds a pause before the data byte
   task automatic cmd(input logic [7:0] id, ins, dat, input int n);
      logic [7:0] r;
      host.start();
      host.xfer(id, r);
      host.xfer(ins, r);
      if (n > 3) host.pause();
      if (n > 2) host.xfer(dat, rd);
      host.stop();
      repeat (8) @(negedge clk);
   endtask
   task automatic step(input logic [1:0] pot, input int up, dn);
      logic [7:0] r;
      host.start();
      host.xfer(ID1, r);
      host.xfer({OP_INCDEC, 2'h0, pot}, r);
      repeat (up) host.bit1(1'b1, r[0]);
      repeat (dn) host.bit1(1'b0, r[0]);
      host.stop();
      repeat (8) @(negedge clk);
   endtask
   task automatic waitSave();
      int n = 0;
      while (writeInProgress !== 1'b0 && n < NV + 8) begin
         @(negedge clk);
         n++;
      end
      check("save length", n < NV, 1'b1);
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // Watchdog
   initial begin
      #200000;
      bad_count++;
      print_verdict();
   end
   // Main sequence
   initial begin
      repeat (12) @(negedge clk);
      reset = 1'b0;
      repeat (6) @(negedge clk);
      for (int p = 0; p < 4; p++) check("reset tap", tapEnable[p], TAP_RESET);
      for (int p = 0; p < 4; p++) cmd(ID1, {OP_WR_WIPER, 2'h0, 2'(p)}, {2'h0, vals[p]}, 3);
      for (int p = 0; p < 4; p++) begin
         cmd(ID1, {OP_RD_WIPER, 2'h0, 2'(p)}, 8'h00, 3);
         check("wiper read", rd, {2'h0, vals[p]});
         check("wiper tap", tapEnable[p], 64'h1 << vals[p]);
         cmd(ID1, {OP_RD_SET, 2'(p), 2'(p)}, 8'h00, 3);
         check("setting reset", rd, {2'h0, SETTING_RESET});
      end
      cmd(ID1, {OP_WR_SET, 2'h1, 2'h2}, 8'h15, 3);
      cmd(ID1, {OP_RD_STATUS, 4'h0}, 8'h00, 3);
      check("status busy", rd, 8'h01);
      waitSave();
      cmd(ID1, {OP_RD_STATUS, 4'h0}, 8'h00, 3);
      check("status idle", rd, 8'h00);
      cmd(ID1, {OP_RD_SET, 2'h1, 2'h2}, 8'h00, 3);
      check("setting read", rd, 8'h15);
      cmd(ID1, {OP_XFR_SET_TO_WIPER, 2'h1, 2'h2}, 8'h00, 2);
      check("xfr tap", tapEnable[2], 64'h1 << 6'h15);
      cmd(ID1, {OP_XFR_WIPER_TO_SET, 2'h2, 2'h1}, 8'h00, 2);
      waitSave();
      cmd(ID1, {OP_RD_SET, 2'h2, 2'h1}, 8'h00, 3);
      check("wiper saved", rd, 8'h3f);
      cmd(ID1, {OP_GXFR_WIPER_TO_SET, 2'h3, 2'h0}, 8'h00, 2);
      waitSave();
      cmd(ID1, {OP_GXFR_SET_TO_WIPER, 2'h1, 2'h0}, 8'h00, 2);
      for (int p = 0; p < 4; p++) check("global sel1", tapEnable[p], 64'h1 << (p == 2 ? 6'h15 : 6'h20));
      cmd(ID1, {OP_GXFR_SET_TO_WIPER, 2'h3, 2'h0}, 8'h00, 2);
      for (int p = 0; p < 4; p++) check("global sel3", tapEnable[p], 64'h1 << g3[p]);
      writeProtectN = 1'b0;
      cmd(ID1, {OP_WR_SET, 2'h0, 2'h3}, 8'h3e, 3);
      check("protected flag", writeInProgress, 1'b0);
      cmd(ID1, {OP_RD_SET, 2'h0, 2'h3}, 8'h00, 3);
      check("protected setting", rd, {2'h0, SETTING_RESET});
      writeProtectN = 1'b1;
      step(2'h3, 4, 1);
      check("step up", tapEnable[3], 64'h1 << 6'h14);
      step(2'h0, 0, 2);
      check("step floor", tapEnable[0], 64'h1);
      cmd(ID1 ^ 8'h40, {OP_WR_WIPER, 2'h0, 2'h3}, 8'h01, 3);
      cmd(ID1 ^ 8'h03, {OP_WR_WIPER, 2'h0, 2'h3}, 8'h01, 3);
      check("id mismatch", tapEnable[3], 64'h1 << 6'h14);
      deviceSelect = 2'h2;
      cmd(ID1 ^ 8'h03, {OP_WR_WIPER, 2'h0, 2'h3}, 8'h01, 4);
      check("paused write", tapEnable[3], 64'h2);
      cmd(ID1 ^ 8'h03, {4'h7, 2'h0, 2'h3}, 8'h05, 3);
      check("unknown opcode", tapEnable[3], 64'h2);
      reset = 1'b1;
      repeat (12) @(negedge clk);
      reset = 1'b0;
      repeat (6) @(negedge clk);
      for (int p = 0; p < 4; p++) check("second reset", tapEnable[p], TAP_RESET);
      print_verdict();
   end
endmodule // tb
`default_nettype wire
